// File: common/adc_regmap_pkg.sv
// Purpose: Shared constants and carriers for the ADC register bank
// Assumes: Command words arrive whole, already assembled by the port logic
// Notes:   Registers hold the nine payload bits; readback adds the select
package adc_regmap_pkg;

  // ==========================================================
  // Command word layout
  localparam int unsigned CMD_WIDTH     = 16;
  localparam int unsigned SELECT_WIDTH  = 6;
  localparam int unsigned LOWER_WIDTH   = 5;
  localparam int unsigned PAYLOAD_WIDTH = 9;

  typedef struct packed {
    logic                     write;          // Bit 15
    logic                     stack_space;    // Bit 14, select bit 5
    logic [LOWER_WIDTH-1:0]   lower_select;   // Bits 13..9
    logic [PAYLOAD_WIDTH-1:0] payload;        // Bits 8..0
  } cmd_word_t;

  // ==========================================================
  // Lower select codes in ordinary register space
  localparam logic [LOWER_WIDTH-1:0] SEL_CONVERSION = 5'h00;
  localparam logic [LOWER_WIDTH-1:0] SEL_RESERVED   = 5'h01;
  localparam logic [LOWER_WIDTH-1:0] SEL_CONFIG     = 5'h02;
  localparam logic [LOWER_WIDTH-1:0] SEL_CHANNEL    = 5'h03;
  localparam logic [LOWER_WIDTH-1:0] SEL_RANGE_A1   = 5'h04;
  localparam logic [LOWER_WIDTH-1:0] SEL_RANGE_A2   = 5'h05;
  localparam logic [LOWER_WIDTH-1:0] SEL_RANGE_B1   = 5'h06;
  localparam logic [LOWER_WIDTH-1:0] SEL_RANGE_B2   = 5'h07;
  localparam logic [LOWER_WIDTH-1:0] SEL_STATUS     = 5'h08;

  // ==========================================================
  // Reset values
  localparam logic [PAYLOAD_WIDTH-1:0] CONFIG_RESET  = 9'h000;
  localparam logic [PAYLOAD_WIDTH-1:0] CHANNEL_RESET = 9'h000;
  localparam logic [PAYLOAD_WIDTH-1:0] RANGE_RESET   = 9'h0FF;
  localparam logic [PAYLOAD_WIDTH-1:0] LAYER_CLEAR   = 9'h000;
  localparam logic [CMD_WIDTH-1:0]     RDATA_RESET   = 16'h0000;

  // ==========================================================
  // Configuration field positions
  localparam int unsigned CFG_SELF_ERR  = 7;
  localparam int unsigned CFG_BURST     = 6;
  localparam int unsigned CFG_SEQ       = 5;
  localparam int unsigned CFG_RATIO_MSB = 4;
  localparam int unsigned CFG_RATIO_LSB = 2;
  localparam int unsigned CFG_STATUS_EN = 1;
  localparam int unsigned CFG_CRC_EN    = 0;
  localparam int unsigned RATIO_WIDTH   = 3;
  localparam int unsigned FACTOR_WIDTH  = 8;
  localparam logic [FACTOR_WIDTH-1:0] FACTOR_ONE = 8'h01;

  // ==========================================================
  // Sequencer stack
  localparam int unsigned NUM_LAYERS   = 32;
  localparam int unsigned INIT_LAYERS  = 8;
  localparam int unsigned LAYER_IDX_W  = 5;
  localparam int unsigned PICK_WIDTH   = 4;
  localparam int unsigned LAYER_LAST   = 8;   // Last-layer flag position

  typedef struct packed {
    logic                  last_layer;
    logic [PICK_WIDTH-1:0] channel_b;
    logic [PICK_WIDTH-1:0] channel_a;
  } layer_t;

  // ==========================================================
  // Status word: last pair in the upper byte, checksum in the lower
  typedef struct packed {
    logic [PICK_WIDTH-1:0] pair_a;
    logic [PICK_WIDTH-1:0] pair_b;
    logic [7:0]            checksum;
  } status_word_t;

endpackage : adc_regmap_pkg

// File: design/adc_register_map_access.sv
// Purpose: Software-mode register bank and command decoder
// Assumes: cmd_valid is a one-cycle strobe from port logic on sys_clk
// Notes:   Read answers appear one cycle after the command on rd_data
module adc_register_map_access
  import adc_regmap_pkg::*;
(
  input  wire logic                                sys_clk,
  input  wire logic                                nrst,
  input  wire logic                                partial_reset,
  input  wire logic                                cmd_valid,
  input  wire adc_regmap_pkg::cmd_word_t           cmd_word,
  input  wire logic                                self_detect_error_flag,
  input  wire adc_regmap_pkg::status_word_t        status_word,
  input  wire logic [adc_regmap_pkg::LAYER_IDX_W-1:0] layer_index,
  output logic [adc_regmap_pkg::PAYLOAD_WIDTH-1:0] device_configuration,
  output logic [adc_regmap_pkg::PAYLOAD_WIDTH-1:0] channel_selection,
  output logic [adc_regmap_pkg::PAYLOAD_WIDTH-1:0] input_range_a_low,
  output logic [adc_regmap_pkg::PAYLOAD_WIDTH-1:0] input_range_a_high,
  output logic [adc_regmap_pkg::PAYLOAD_WIDTH-1:0] input_range_b_low,
  output logic [adc_regmap_pkg::PAYLOAD_WIDTH-1:0] input_range_b_high,
  output adc_regmap_pkg::layer_t                   layer_data,
  output logic                                     status_append_enable,
  output logic [adc_regmap_pkg::FACTOR_WIDTH-1:0]  oversample_factor,
  output logic                                     rd_valid,
  output logic                                     rd_conversion,
  output logic [adc_regmap_pkg::CMD_WIDTH-1:0]     rd_data
);
  import adc_regmap_pkg::*;

  // ==========================================================
  // Command decode
  logic                     do_write;
  logic                     do_read;
  logic                     ordinary;
  logic [LOWER_WIDTH-1:0]   lower;
  logic [SELECT_WIDTH-1:0]  register_select;
  layer_t                   sequence_layers [NUM_LAYERS];

  assign register_select = {cmd_word.stack_space, cmd_word.lower_select};
  assign lower           = cmd_word.lower_select;
  assign ordinary        = ~cmd_word.stack_space;
  assign do_write        = cmd_valid & cmd_word.write;
  assign do_read         = cmd_valid & ~cmd_word.write;

  // ==========================================================
  // Ordinary registers; reserved and status writes fall through
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      device_configuration <= CONFIG_RESET;
      channel_selection    <= CHANNEL_RESET;
      input_range_a_low    <= RANGE_RESET;
      input_range_a_high   <= RANGE_RESET;
      input_range_b_low    <= RANGE_RESET;
      input_range_b_high   <= RANGE_RESET;
    end else if (do_write && ordinary) begin
      unique case (lower)
        SEL_CONFIG: begin
          device_configuration <= cmd_word.payload;
          // Error flag belongs to the self test, never to software
          device_configuration[CFG_SELF_ERR] <= 1'b0;
        end
        SEL_CHANNEL:  channel_selection  <= cmd_word.payload;
        SEL_RANGE_A1: input_range_a_low  <= cmd_word.payload;
        SEL_RANGE_A2: input_range_a_high <= cmd_word.payload;
        SEL_RANGE_B1: input_range_b_low  <= cmd_word.payload;
        SEL_RANGE_B2: input_range_b_high <= cmd_word.payload;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Sequencer stack, one flop group per layer
  // Partial reset outranks a stack write in the same cycle
  for (genvar g = 0; g < NUM_LAYERS; g++) begin : g_layer
    localparam layer_t INIT = (g < INIT_LAYERS) ?
        {1'b0, PICK_WIDTH'(g), PICK_WIDTH'(g)} : layer_t'(LAYER_CLEAR);
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        sequence_layers[g] <= INIT;
      end else if (partial_reset) begin
        sequence_layers[g] <= INIT;
      end else if (do_write && cmd_word.stack_space &&
                   lower == LAYER_IDX_W'(g)) begin
        sequence_layers[g] <= layer_t'(cmd_word.payload);
      end
    end
  end

  // Sequencer read port, one cycle of latency
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      layer_data <= layer_t'(LAYER_CLEAR);
    end else begin
      layer_data <= sequence_layers[layer_index];
    end
  end

  // ==========================================================
  // Decoded configuration fields
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      status_append_enable <= 1'b0;
    end else begin
      status_append_enable <= device_configuration[CFG_STATUS_EN] |
                              device_configuration[CFG_CRC_EN];
    end
  end

  // Code 0 means one sample per channel, i.e. no oversampling
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      oversample_factor <= FACTOR_ONE;
    end else begin
      oversample_factor <= FACTOR_ONE <<
          device_configuration[CFG_RATIO_MSB:CFG_RATIO_LSB];
    end
  end

  // ==========================================================
  // Read answer
  logic [PAYLOAD_WIDTH-1:0] next_payload;
  logic                     next_known;

  always_comb begin
    next_payload = LAYER_CLEAR;
    next_known   = 1'b1;
    if (!ordinary) begin
      next_payload = sequence_layers[lower];
    end else begin
      unique case (lower)
        SEL_CONFIG: begin
          next_payload           = device_configuration;
          next_payload[CFG_SELF_ERR] = self_detect_error_flag;
        end
        SEL_CHANNEL:  next_payload = channel_selection;
        SEL_RANGE_A1: next_payload = input_range_a_low;
        SEL_RANGE_A2: next_payload = input_range_a_high;
        SEL_RANGE_B1: next_payload = input_range_b_low;
        SEL_RANGE_B2: next_payload = input_range_b_high;
        default:      next_known   = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid      <= 1'b0;
      rd_conversion <= 1'b0;
      rd_data       <= RDATA_RESET;
    end else begin
      rd_valid      <= do_read;
      rd_conversion <= do_read && ordinary &&
                       lower == SEL_CONVERSION;
      if (do_read) begin
        if (ordinary && lower == SEL_STATUS) begin
          rd_data <= status_word;
        end else if (next_known) begin
          rd_data <= {1'b0, register_select, next_payload};
        end else begin
          // Conversion and reserved reads carry no register data
          rd_data <= RDATA_RESET;
        end
      end
    end
  end

  // ==========================================================
  // Checks
  sequence cmd_write_s(logic [LOWER_WIDTH-1:0] code);
    do_write && ordinary && lower == code;
  endsequence

  sequence cmd_read_s(logic [LOWER_WIDTH-1:0] code);
    do_read && ordinary && lower == code;
  endsequence

  config_write_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    cmd_write_s(SEL_CONFIG) |=> device_configuration ==
      ($past(cmd_word.payload) & ~(9'h001 << CFG_SELF_ERR)))
    else $error("config register did not take payload");

  range_write_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    cmd_write_s(SEL_RANGE_B1) |=>
      input_range_b_low == $past(cmd_word.payload) &&
      $stable(input_range_a_low) && $stable(input_range_b_high))
    else $error("range write went to wrong register");

  ignored_write_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (cmd_write_s(SEL_RESERVED) or cmd_write_s(SEL_STATUS)) |=>
      $stable(device_configuration) && $stable(channel_selection) &&
      $stable(input_range_a_low) && $stable(input_range_b_high))
    else $error("reserved or status write changed a register");

  stack_write_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (do_write && cmd_word.stack_space && !partial_reset) ##1
      (layer_index == $past(lower)) |=>
      layer_data == layer_t'($past(cmd_word.payload, 2)))
    else $error("stack layer did not take payload");

  stack_reinit_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    partial_reset |=> sequence_layers[3] == layer_t'(9'h033) &&
      sequence_layers[20] == layer_t'(LAYER_CLEAR))
    else $error("stack not reinitialised");

  conv_read_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    cmd_read_s(SEL_CONVERSION) |=> rd_valid && rd_conversion ##1
      !rd_conversion || $past(do_read))
    else $error("conversion read not flagged");

  status_read_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    cmd_read_s(SEL_STATUS) |=> rd_valid &&
      rd_data[15:8] == {$past(status_word.pair_a),
                        $past(status_word.pair_b)} &&
      rd_data[7:0] == $past(status_word.checksum))
    else $error("status word read wrong");

  append_enable_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ##1 status_append_enable == ($past(device_configuration[CFG_STATUS_EN])
                             || $past(device_configuration[CFG_CRC_EN])))
    else $error("status append enable wrong");

  os_factor_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    device_configuration[CFG_RATIO_MSB:CFG_RATIO_LSB] == 3'h7 |=>
      oversample_factor == 8'h80)
    else $error("oversampling ratio wrong");

  read_payload_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    cmd_read_s(SEL_CHANNEL) |=> rd_valid &&
      rd_data[PAYLOAD_WIDTH-1:0] == $past(channel_selection))
    else $error("channel register read wrong");

  channel_write_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    cmd_write_s(SEL_CHANNEL) |=>
      channel_selection == $past(cmd_word.payload) &&
      $stable(device_configuration))
    else $error("channel register did not take payload");

  reserved_read_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    cmd_read_s(SEL_RESERVED) |=> rd_valid && !rd_conversion &&
      rd_data == RDATA_RESET)
    else $error("reserved read returned data");

  stack_read_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (do_read && cmd_word.stack_space) |=> rd_valid && !rd_conversion &&
      rd_data == {1'b0, $past(register_select),
                  $past(sequence_layers[lower])})
    else $error("stack layer read wrong");

  reinit_ends_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    partial_reset |=>
      sequence_layers[INIT_LAYERS-1] == layer_t'(9'h077) &&
      sequence_layers[NUM_LAYERS-1] == layer_t'(LAYER_CLEAR))
    else $error("stack ends not reinitialised");

  write_silent_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    do_write |=> !rd_valid && !rd_conversion)
    else $error("write produced a read answer");

  answer_hold_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    !do_read |=> $stable(rd_data) && !rd_valid)
    else $error("read answer changed without a read");

  config_guard_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    do_write && !(ordinary && lower == SEL_CONFIG) |=>
      $stable(device_configuration))
    else $error("config register changed by another write");

endmodule : adc_register_map_access

// File: dv/host_model.sv
// Purpose: Host controller issuing command words to the register bank
// Assumes: One command at a time; answer is sampled in the following cycle
// Notes:   Idle command bits toggle so a stale word never reads as valid
module host_model
  import adc_regmap_pkg::*;
(
  input  wire logic                            sys_clk,
  input  wire logic                            rd_valid,
  input  wire logic                            rd_conversion,
  input  wire logic [adc_regmap_pkg::CMD_WIDTH-1:0] rd_data,
  output adc_regmap_pkg::cmd_word_t            cmd_word,
  output logic                                 cmd_valid
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Command cycle
  initial begin
    cmd_valid = 1'b0;
    cmd_word  = '0;
  end

  task automatic command(input cmd_word_t w, output logic [15:0] d,
                         output logic v, output logic c);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_word  <= w;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    cmd_word  <= ~w;
    #1;
    v = rd_valid;
    c = rd_conversion;
    d = rd_data;
  endtask : command
endmodule : host_model

// File: dv/testbench.sv
// Purpose: Self-checking bench for the register bank
// Assumes: Host model forms and sends whole command words
// Notes:   Expectations follow the readback layout {0, select, payload}
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_regmap_pkg::*;

  // ==========================================================
  // Signals
  logic         sys_clk;
  logic         nrst;
  logic         partial_reset;
  logic         self_detect_error_flag;
  status_word_t status_word;
  logic [4:0]   layer_index;
  cmd_word_t    cmd_word;
  logic         cmd_valid;
  logic [8:0]   cfg;
  logic [8:0]   chan;
  logic [8:0]   ra_lo;
  logic [8:0]   ra_hi;
  logic [8:0]   rb_lo;
  logic [8:0]   rb_hi;
  layer_t       layer_data;
  logic         status_append_enable;
  logic [7:0]   oversample_factor;
  logic         rd_valid;
  logic         rd_conversion;
  logic [15:0]  rd_data;
  int           n_mismatch;
  int           checked;
  int           cycles;

`define CHECK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end

  adc_register_map_access u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .partial_reset(partial_reset),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .self_detect_error_flag(self_detect_error_flag),
    .status_word(status_word), .layer_index(layer_index),
    .device_configuration(cfg), .channel_selection(chan),
    .input_range_a_low(ra_lo), .input_range_a_high(ra_hi),
    .input_range_b_low(rb_lo), .input_range_b_high(rb_hi),
    .layer_data(layer_data), .status_append_enable(status_append_enable),
    .oversample_factor(oversample_factor), .rd_valid(rd_valid),
    .rd_conversion(rd_conversion), .rd_data(rd_data));

  host_model u_host (
    .sys_clk(sys_clk), .rd_valid(rd_valid), .rd_conversion(rd_conversion),
    .rd_data(rd_data), .cmd_word(cmd_word), .cmd_valid(cmd_valid));

  // ==========================================================
  // Access helpers
  task automatic wr(input logic [5:0] s, input logic [8:0] x);
    logic [15:0] d;
    logic        v;
    logic        c;
    u_host.command(cmd_word_t'({1'b1, s, x}), d, v, c);
    `CHECK(v, 1'b0)
  endtask : wr

  task automatic rd(input logic [5:0] s, input logic [15:0] e,
                    input logic ec);
    logic [15:0] d;
    logic        v;
    logic        c;
    u_host.command(cmd_word_t'({1'b0, s, 9'h000}), d, v, c);
    `CHECK(v, 1'b1)
    `CHECK(c, ec)
    `CHECK(d, e)
  endtask : rd

  task automatic peek(input logic [4:0] k, input logic [8:0] e);
    @(posedge sys_clk);
    layer_index <= k;
    @(posedge sys_clk);
    #1;
    `CHECK(layer_data, e)
  endtask : peek

  // ==========================================================
  // Scenarios
  task automatic t_reset_values;
    for (int k = 2; k < 8; k++)
      rd(6'(k), {1'b0, 6'(k), (k < 4) ? 9'h000 : 9'h0FF}, 1'b0);
    for (int k = 0; k < 32; k++)
      peek(5'(k), (k < 8) ? 9'(k) * 9'h011 : 9'h000);
    `CHECK(oversample_factor, 8'h01)
    `CHECK(status_append_enable, 1'b0)
  endtask : t_reset_values

  task automatic t_write_read;
    wr(6'h02, 9'h1A5);
    `CHECK(cfg, 9'h125)
    @(posedge sys_clk);
    self_detect_error_flag <= 1'b1;
    rd(6'h02, 16'h05A5, 1'b0);
    self_detect_error_flag <= 1'b0;
    for (int k = 3; k < 8; k++) begin
      wr(6'(k), 9'h100 | 9'(k));
      rd(6'(k), {1'b0, 6'(k), 9'h100 | 9'(k)}, 1'b0);
    end
    `CHECK({chan, ra_lo, ra_hi, rb_lo, rb_hi},
           {9'h103, 9'h104, 9'h105, 9'h106, 9'h107})
  endtask : t_write_read

  task automatic t_config_fields;
    for (int k = 0; k < 8; k++) begin
      wr(6'h02, 9'(k << 2) | 9'(k & 3));
      @(posedge sys_clk);
      #1;
      `CHECK(oversample_factor, 8'h01 << k)
      `CHECK(status_append_enable, (k & 3) != 0)
    end
  endtask : t_config_fields

  task automatic t_ignored;
    wr(6'h00, 9'h1FF);
    wr(6'h01, 9'h1FF);
    wr(6'h08, 9'h1FF);
    wr(6'h09, 9'h1FF);
    wr(6'h1F, 9'h1FF);
    `CHECK({cfg, chan, ra_lo, rb_hi},
           {9'h01F, 9'h103, 9'h104, 9'h107})
    rd(6'h01, 16'h0000, 1'b0);
  endtask : t_ignored

  task automatic t_status_conv;
    @(posedge sys_clk);
    status_word <= status_word_t'(16'hA53C);
    rd(6'h08, 16'hA53C, 1'b0);
    rd(6'h00, 16'h0000, 1'b1);
  endtask : t_status_conv

  task automatic t_stack;
    wr(6'h20, 9'h1EF);
    wr(6'h25, 9'h0C3);
    wr(6'h3F, 9'h155);
    peek(5'h00, 9'h1EF);
    peek(5'h05, 9'h0C3);
    peek(5'h1F, 9'h155);
    rd(6'h3F, 16'h7F55, 1'b0);
    @(posedge sys_clk);
    partial_reset <= 1'b1;
    @(posedge sys_clk);
    partial_reset <= 1'b0;
    peek(5'h00, 9'h000);
    peek(5'h05, 9'h055);
    peek(5'h1F, 9'h000);
    `CHECK(cfg, 9'h01F)
  endtask : t_stack

  // ==========================================================
  // Run control
  task automatic give_verdict;
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Whole run needs well under two thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    n_mismatch = 0;
    checked = 0;
    cycles = 0;
    nrst = 1'b0;
    partial_reset = 1'b0;
    self_detect_error_flag = 1'b0;
    status_word = '0;
    layer_index = '0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset_values();
    t_write_read();
    t_config_fields();
    t_ignored();
    t_status_conv();
    t_stack();
    give_verdict();
  end
endmodule : testbench
